// [verif/lise_host_model.sv]
`timescale 1ns/1ps
module lise_host_model
   import lise_pkg::*;
(
   input wire logic i_ref_clk, // Bus clock
   output lise_reg_req_s o_req, // Register access
   output logic o_counters_read // Counter sweep done
);
   // Registers outside this block, offsets and bits arbitrary
   localparam logic [7:0] CHIP_CONTROL_OFS = 8'h30;
   localparam logic [15:0] CHIP_RESET_BITS = 16'h0003;
   localparam logic [7:0] SEND_STATUS_OFS = 8'h46;
   // Idle bus at start
   initial begin
      o_req = '0;
      o_counters_read = 1'b0;
   end
   // One register cycle, lines turn over once released
   task automatic acc(input logic r, input logic w, input logic [7:0] a,
      input logic [15:0] d);
      @(posedge i_ref_clk);
      o_req <= '{rd: r, wr: w, addr: a, wdata: d};
      @(posedge i_ref_clk);
      o_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
   endtask : acc
   // Chip and DMA reset after a bus fault
   task automatic recover();
      acc(1'b0, 1'b1, CHIP_CONTROL_OFS, CHIP_RESET_BITS);
   endtask : recover
   // Advance the send status queue
   task automatic advance_send();
      acc(1'b0, 1'b1, SEND_STATUS_OFS, 16'h0000);
   endtask : advance_send
   // Service sweep of all counters
   task automatic sweep();
      @(posedge i_ref_clk);
      o_counters_read <= 1'b1;
      @(posedge i_ref_clk);
      o_counters_read <= 1'b0;
   endtask : sweep
endmodule : lise_host_model

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
   import lise_pkg::*;
   typedef struct packed {
      lise_events_s evt;
      logic [15:0] st;
   } lise_row_s;
   logic i_ref_clk;
   logic i_reset_n;
   lise_reg_req_s req;
   lise_events_s evt;
   logic arr_ack;
   logic cnt_rd;
   logic [15:0] rdata;
   logic irq_n;
   logic [15:0] mask;
   int compares = 0;
   int miscompares = 0;
   // One source per row with its status bit
   lise_row_s rows[9] = '{'{9'h100, 16'h0002}, '{9'h080, 16'h0004},
      '{9'h040, 16'h0008}, '{9'h020, 16'h0010}, '{9'h010, 16'h0040},
      '{9'h008, 16'h0080}, '{9'h004, 16'h0100}, '{9'h002, 16'h0200},
      '{9'h001, 16'h0400}};

   lise_top i_lise_top (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_req(req),
      .i_evt(evt),
      .i_arrived_ack(arr_ack),
      .i_counters_read(cnt_rd),
      .o_rdata(rdata),
      .o_bus_irq_pin_n(irq_n),
      .o_interrupt_source_mask(mask)
   );
   lise_host_model i_lise_host_model (
      .i_ref_clk(i_ref_clk),
      .o_req(req),
      .o_counters_read(cnt_rd)
   );

   // Clock
   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
      i_lise_host_model.acc(1'b1, 1'b0, a, 16'h0000);
      #1;
      chk(rdata, e);
   endtask : rd_chk
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      i_lise_host_model.acc(1'b0, 1'b1, a, d);
   endtask : wr
   task automatic pulse(input lise_events_s e);
      @(posedge i_ref_clk);
      evt <= e;
      @(posedge i_ref_clk);
      evt <= '0;
   endtask : pulse
   task automatic give_verdict();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict

   // Watchdog
   initial begin
      #50us;
      miscompares++;
      give_verdict();
   end

   // Main sequence
   initial begin
      i_reset_n = 1'b0;
      evt = '0;
      arr_ack = 1'b0;
      repeat (16) @(posedge i_ref_clk);
      i_reset_n <= 1'b1;
      rd_chk(LISE_OFS_STATUS, LISE_STATUS_RST);
      chk(mask, LISE_MASK_RST);
      chk({15'h0, irq_n}, 16'h0001);
      foreach (rows[i]) for (int en = 0; en < 2; en++) begin
         wr(LISE_OFS_MASK, en ? rows[i].st : 16'h0000);
         pulse(rows[i].evt);
         rd_chk(LISE_OFS_STATUS, rows[i].st | 16'(en));
         chk({15'h0, irq_n}, 16'(1 - en));
         rd_chk(LISE_OFS_ACK, rows[i].st | 16'(en));
         chk(mask, 16'h0000);
         if (i == 0) i_lise_host_model.recover();
         if (i == 1) i_lise_host_model.advance_send();
         wr(LISE_OFS_STATUS, 16'h0000);
         rd_chk(LISE_OFS_STATUS, rows[i].st & ~LISE_ACK_CLR);
         wr(LISE_OFS_STATUS, 16'hFFFF);
         rd_chk(LISE_OFS_STATUS, 16'h0000);
      end
      // Receive engine acknowledge
      pulse(9'h020);
      rd_chk(LISE_OFS_STATUS, 16'h0010);
      @(posedge i_ref_clk);
      arr_ack <= 1'b1;
      @(posedge i_ref_clk);
      arr_ack <= 1'b0;
      rd_chk(LISE_OFS_STATUS, 16'h0000);
      // Counter sweep clears nearfull
      pulse(9'h008);
      rd_chk(LISE_OFS_STATUS, 16'h0080);
      i_lise_host_model.sweep();
      rd_chk(LISE_OFS_STATUS, 16'h0000);
      // Event in the same cycle as its clearing write
      fork
         wr(LISE_OFS_STATUS, 16'h0100);
         pulse(9'h004);
      join
      rd_chk(LISE_OFS_STATUS, 16'h0100);
      wr(LISE_OFS_MASK, 16'hFFFF);
      #1;
      chk(mask, LISE_MASK_WR);
      rd_chk(LISE_OFS_MASK, LISE_MASK_WR);
      rd_chk(8'h50, 16'h0000);
      // Reset in mid-run with an interrupt pending
      pulse(9'h004);
      rd_chk(LISE_OFS_STATUS, 16'h0101);
      chk({15'h0, irq_n}, 16'h0000);
      @(posedge i_ref_clk);
      i_reset_n <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      i_reset_n <= 1'b1;
      @(posedge i_ref_clk);
      #1;
      chk({15'h0, irq_n}, 16'h0001);
      chk(mask, LISE_MASK_RST);
      rd_chk(LISE_OFS_STATUS, LISE_STATUS_RST);
      give_verdict();
   end
endmodule : tb

// [verilog/lise_pkg.sv]
package lise_pkg;
   // Register offsets (I/O byte offsets)
   localparam logic [7:0] LISE_OFS_ACK = 8'h4A;
   localparam logic [7:0] LISE_OFS_STATUS = 8'h4E;
   localparam logic [7:0] LISE_OFS_MASK = 8'h4C;
   // Reset values
   localparam logic [15:0] LISE_STATUS_RST = 16'h0000;
   localparam logic [15:0] LISE_MASK_RST = 16'h0000;
   // Field positions
   localparam int LISE_B_SUMMARY = 0;
   localparam int LISE_B_BUS_FAULT = 1;
   localparam int LISE_B_FRAME_SENT = 2;
   localparam int LISE_B_CTRL_FRAME = 3;
   localparam int LISE_B_FRAME_ARRIVED = 4;
   localparam int LISE_B_SW_REQ = 6;
   localparam int LISE_B_NEARFULL = 7;
   localparam int LISE_B_LINK = 8;
   localparam int LISE_B_SEND_DMA = 9;
   localparam int LISE_B_RECV_DMA = 10;
   // Implemented event flag bits: 1..4 and 6..10
   localparam logic [15:0] LISE_FLAG_MASK = 16'h07DE;
   // Bits cleared by a read of the acknowledging alias
   localparam logic [15:0] LISE_ACK_CLR = 16'h0748;
   // Mask register: bits 1..10 writable, bit 5 kept as storage
   localparam logic [15:0] LISE_MASK_WR = 16'h07FE;

   // Event pulses from the rest of the chip, one per source
   typedef struct packed {
      logic bus_fault;
      logic frame_sent;
      logic ctrl_frame;
      logic frame_arrived;
      logic sw_req;
      logic nearfull;
      logic link;
      logic send_dma;
      logic recv_dma;
   } lise_events_s;

   // Register access port
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [15:0] wdata;
   } lise_reg_req_s;

   // Block state
   typedef struct packed {
      logic [15:0] flags;
      logic [15:0] mask;
      logic [15:0] rdata;
      logic irq_n;
   } lise_state_s;
endpackage : lise_pkg

// [verilog/lise_top.sv]
`timescale 1ns/1ps
// How it works
// R1: Enabled flags only reach the interrupt
// R2: Alias read zeroes the whole mask
// R3: Summary bit is OR of masked flags
// R4: Interrupt pin low while summary bit set
// R5: Writing one clears flag, zero keeps
// R6: Bus abort sets bus fault flag
// R7: Software resets chip after bus fault
// R8: Sent or failed frame sets sent flag
// R9: Software writes send status after sent
// R10: Control frame received sets its flag
// R11: Frame in receive buffer sets flag
// R12: Receive engine clears arrival flag itself
// R13: Software request bit sets request flag
// R14: Counter near overflow sets nearfull flag
// R15: Reading all counters clears nearfull flag
// R16: Link state change sets link flag
// R17: Requested send DMA done sets flag
// R18: Receive DMA done sets its flag
// R19: Alias returns identical status value
// R20: Alias read clears five event flags
// R21: Same-cycle set beats clear
module lise_top
   import lise_pkg::*;
(
   input wire logic i_ref_clk, // 100 MHz clock
   input wire logic i_reset_n, // Sync reset, active low
   input wire lise_reg_req_s i_req, // Register access
   input wire lise_events_s i_evt, // Event pulses
   input wire logic i_arrived_ack, // Receive engine took frames
   input wire logic i_counters_read, // All counters read
   output logic [15:0] o_rdata, // Read data, one cycle later
   output logic o_bus_irq_pin_n, // Bus interrupt, active low
   output logic [15:0] o_interrupt_source_mask // Mask view
);
   lise_state_s s_q;
   lise_state_s s_d;
   logic [15:0] set_v;
   logic [15:0] clr_v;
   logic [15:0] flags_nx;
   logic [15:0] mask_nx;
   logic [15:0] view_c;
   logic [15:0] irq_view;
   logic rd_ack;
   logic rd_stat;
   logic wr_stat;
   logic wr_mask;

   // Status view with summary bit in position 0
   function automatic logic [15:0] status_view(input logic [15:0] f,
                                               input logic [15:0] m);
      logic [15:0] v;
      v = f & LISE_FLAG_MASK;
      v[LISE_B_SUMMARY] = |(f & m & LISE_FLAG_MASK); // R1 R3
      return v;
   endfunction : status_view

   // Address decode
   assign rd_ack = i_req.rd && (i_req.addr == LISE_OFS_ACK);
   assign rd_stat = i_req.rd && (i_req.addr == LISE_OFS_STATUS);
   assign wr_stat = i_req.wr && (i_req.addr == LISE_OFS_STATUS);
   assign wr_mask = i_req.wr && (i_req.addr == LISE_OFS_MASK);
   assign view_c = status_view(s_q.flags, s_q.mask);

   // Next state
   always_comb begin
      s_d = s_q;
      set_v = 16'h0000;
      set_v[LISE_B_BUS_FAULT] = i_evt.bus_fault; // R6
      set_v[LISE_B_FRAME_SENT] = i_evt.frame_sent; // R8
      set_v[LISE_B_CTRL_FRAME] = i_evt.ctrl_frame; // R10
      set_v[LISE_B_FRAME_ARRIVED] = i_evt.frame_arrived; // R11
      set_v[LISE_B_SW_REQ] = i_evt.sw_req; // R13
      set_v[LISE_B_NEARFULL] = i_evt.nearfull; // R14
      set_v[LISE_B_LINK] = i_evt.link; // R16
      set_v[LISE_B_SEND_DMA] = i_evt.send_dma; // R17
      set_v[LISE_B_RECV_DMA] = i_evt.recv_dma; // R18
      clr_v = 16'h0000;
      if (wr_stat) begin
         clr_v = i_req.wdata & LISE_FLAG_MASK; // R5
      end
      if (rd_ack) begin
         clr_v = clr_v | LISE_ACK_CLR; // R20
      end
      clr_v[LISE_B_FRAME_ARRIVED] = clr_v[LISE_B_FRAME_ARRIVED]
                                    | i_arrived_ack; // R12
      clr_v[LISE_B_NEARFULL] = clr_v[LISE_B_NEARFULL]
                               | i_counters_read; // R15
      flags_nx = ((s_q.flags & ~clr_v) | set_v) & LISE_FLAG_MASK; // R21
      mask_nx = s_q.mask;
      if (wr_mask) begin
         mask_nx = i_req.wdata & LISE_MASK_WR;
      end
      if (rd_ack) begin
         mask_nx = LISE_MASK_RST; // R2
      end
      s_d.flags = flags_nx;
      s_d.mask = mask_nx;
      if (rd_ack || rd_stat) begin
         s_d.rdata = view_c; // R19
      end else if (i_req.rd && (i_req.addr == LISE_OFS_MASK)) begin
         s_d.rdata = s_q.mask;
      end else if (i_req.rd) begin
         s_d.rdata = 16'h0000;
      end
      irq_view = status_view(flags_nx, mask_nx);
      s_d.irq_n = ~irq_view[LISE_B_SUMMARY]; // R4
   end

   // State register
   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         s_q.flags <= LISE_STATUS_RST;
         s_q.mask <= LISE_MASK_RST;
         s_q.rdata <= 16'h0000;
         s_q.irq_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_rdata = s_q.rdata;
   assign o_bus_irq_pin_n = s_q.irq_n;
   assign o_interrupt_source_mask = s_q.mask;

   // Checks
   property p_pin_summary;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         o_bus_irq_pin_n == ~view_c[LISE_B_SUMMARY];
   endproperty
   a_pin_summary: assert property (p_pin_summary) // R4
      else $error("irq pin disagrees with summary bit");

   property p_mask_gate;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         ((s_q.flags & s_q.mask) == 16'h0000) |-> o_bus_irq_pin_n;
   endproperty
   a_mask_gate: assert property (p_mask_gate) // R1
      else $error("irq asserted with no enabled flag");

   property p_ack_mask;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         rd_ack |=> (s_q.mask == 16'h0000);
   endproperty
   a_ack_mask: assert property (p_ack_mask) // R2
      else $error("mask not cleared by alias read");

   property p_summary_or;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         view_c[0] == |(s_q.flags & s_q.mask);
   endproperty
   a_summary_or: assert property (p_summary_or) // R3
      else $error("summary bit wrong");

   property p_w1c;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         (wr_stat && i_req.wdata[LISE_B_BUS_FAULT] && !i_evt.bus_fault)
         |=> !s_q.flags[LISE_B_BUS_FAULT];
   endproperty
   a_w1c: assert property (p_w1c) // R5
      else $error("write one did not clear flag");

   property p_fault_set;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         i_evt.bus_fault |=> s_q.flags[LISE_B_BUS_FAULT];
   endproperty
   a_fault_set: assert property (p_fault_set) // R6 R21
      else $error("bus fault flag not set");

   property p_ack_read;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         rd_ack |=> (o_rdata == $past(view_c));
   endproperty
   a_ack_read: assert property (p_ack_read) // R19
      else $error("alias read value wrong");

   property p_ack_clr;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         (rd_ack && !i_evt.link && !i_evt.sw_req)
         |=> !s_q.flags[LISE_B_LINK] && !s_q.flags[LISE_B_SW_REQ];
   endproperty
   a_ack_clr: assert property (p_ack_clr) // R20
      else $error("alias read did not clear flags");

   property p_ack_keep;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         (rd_ack && !wr_stat && !i_counters_read
          && s_q.flags[LISE_B_NEARFULL])
         |=> s_q.flags[LISE_B_NEARFULL];
   endproperty
   a_ack_keep: assert property (p_ack_keep) // R20
      else $error("alias read cleared a kept flag");

   property p_arrived_ack;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         (i_arrived_ack && !i_evt.frame_arrived)
         |=> !s_q.flags[LISE_B_FRAME_ARRIVED];
   endproperty
   a_arrived_ack: assert property (p_arrived_ack) // R12
      else $error("receive engine ack ignored");

   property p_sent_set;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         i_evt.frame_sent |=> s_q.flags[LISE_B_FRAME_SENT];
   endproperty
   a_sent_set: assert property (p_sent_set) // R8
      else $error("frame sent flag not set");

   property p_ctrl_set;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         i_evt.ctrl_frame |=> s_q.flags[LISE_B_CTRL_FRAME];
   endproperty
   a_ctrl_set: assert property (p_ctrl_set) // R10
      else $error("control frame flag not set");

   property p_arrived_set;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         i_evt.frame_arrived |=> s_q.flags[LISE_B_FRAME_ARRIVED];
   endproperty
   a_arrived_set: assert property (p_arrived_set) // R11
      else $error("frame arrived flag not set");

   property p_swreq_set;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         i_evt.sw_req |=> s_q.flags[LISE_B_SW_REQ];
   endproperty
   a_swreq_set: assert property (p_swreq_set) // R13
      else $error("software request flag not set");

   property p_nearfull_set;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         i_evt.nearfull |=> s_q.flags[LISE_B_NEARFULL];
   endproperty
   a_nearfull_set: assert property (p_nearfull_set) // R14
      else $error("nearfull flag not set");

   property p_link_set;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         i_evt.link |=> s_q.flags[LISE_B_LINK];
   endproperty
   a_link_set: assert property (p_link_set) // R16
      else $error("link change flag not set");

   property p_send_dma_set;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         i_evt.send_dma |=> s_q.flags[LISE_B_SEND_DMA];
   endproperty
   a_send_dma_set: assert property (p_send_dma_set) // R17
      else $error("send dma flag not set");

   property p_recv_dma_set;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         i_evt.recv_dma |=> s_q.flags[LISE_B_RECV_DMA];
   endproperty
   a_recv_dma_set: assert property (p_recv_dma_set) // R18
      else $error("receive dma flag not set");

   property p_nearfull_clr;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         (i_counters_read && !i_evt.nearfull)
         |=> !s_q.flags[LISE_B_NEARFULL];
   endproperty
   a_nearfull_clr: assert property (p_nearfull_clr) // R15
      else $error("counter sweep did not clear flag");

   property p_w0_keep;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         (wr_stat && !i_req.wdata[LISE_B_LINK] && !rd_ack
          && s_q.flags[LISE_B_LINK])
         |=> s_q.flags[LISE_B_LINK];
   endproperty
   a_w0_keep: assert property (p_w0_keep) // R5
      else $error("write zero cleared a flag");

   property p_link_race;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         (wr_stat && i_req.wdata[LISE_B_LINK] && i_evt.link)
         |=> s_q.flags[LISE_B_LINK];
   endproperty
   a_link_race: assert property (p_link_race) // R21
      else $error("clear beat a same cycle event");

   property p_ack_clr_dma;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         (rd_ack && !i_evt.send_dma && !i_evt.recv_dma && !i_evt.ctrl_frame)
         |=> !s_q.flags[LISE_B_SEND_DMA] && !s_q.flags[LISE_B_RECV_DMA]
             && !s_q.flags[LISE_B_CTRL_FRAME];
   endproperty
   a_ack_clr_dma: assert property (p_ack_clr_dma) // R20
      else $error("alias read left a dma or control flag");

   property p_ack_keep_arrived;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         (rd_ack && !wr_stat && !i_arrived_ack
          && s_q.flags[LISE_B_FRAME_ARRIVED])
         |=> s_q.flags[LISE_B_FRAME_ARRIVED];
   endproperty
   a_ack_keep_arrived: assert property (p_ack_keep_arrived) // R20
      else $error("alias read cleared arrival flag");

   property p_stat_read;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         rd_stat |=> (o_rdata == $past(view_c));
   endproperty
   a_stat_read: assert property (p_stat_read) // R19
      else $error("status read value wrong");

   property p_flags_legal;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         (s_q.flags & ~LISE_FLAG_MASK) == 16'h0000;
   endproperty
   a_flags_legal: assert property (p_flags_legal) // R5
      else $error("flag set outside event positions");

   property p_mask_write;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         (wr_mask && !rd_ack)
         |=> (s_q.mask == ($past(i_req.wdata) & LISE_MASK_WR));
   endproperty
   a_mask_write: assert property (p_mask_write) // R1
      else $error("mask write did not land");

   property p_irq_on;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         (|(s_q.flags & s_q.mask)) |-> !o_bus_irq_pin_n;
   endproperty
   a_irq_on: assert property (p_irq_on) // R1
      else $error("enabled flag without interrupt");

   property p_rdata_hold;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         !i_req.rd |=> $stable(o_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) // R19
      else $error("read data changed without a read");

   property p_mask_rd;
      @(posedge i_ref_clk) disable iff (!i_reset_n)
         (i_req.rd && (i_req.addr == LISE_OFS_MASK))
         |=> (o_rdata == $past(s_q.mask));
   endproperty
   a_mask_rd: assert property (p_mask_rd) // R1
      else $error("mask read value wrong");

   c_irq: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      $fell(o_bus_irq_pin_n));
   c_ack: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      rd_ack && !o_bus_irq_pin_n);
   c_race: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      wr_stat && i_evt.link && i_req.wdata[LISE_B_LINK]);
   c_fault_clr: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      wr_stat && i_req.wdata[LISE_B_BUS_FAULT] && s_q.flags[LISE_B_BUS_FAULT]);
   c_mask_wr: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n)
      wr_mask && (i_req.wdata != 16'h0000));
endmodule : lise_top
